// ### logic/adc_link_params.svh
`ifndef ADC_LINK_PARAMS_SVH
`define ADC_LINK_PARAMS_SVH

// ----------------------------------------------------------------
// timing figures, in nanoseconds
// ----------------------------------------------------------------
`define CLK_PERIOD_NS      4
`define CONV_TIME_NS       125000000
`define WINDOW_TIME_NS     10000
`define SCLK_HALF_NS       40

// ----------------------------------------------------------------
// result word layout
// ----------------------------------------------------------------
`define RES_FULL_BITS      16
`define RES_BIT_CNT_W      5
`define RED_MAX            3'h6
`define RES_SIGN_ONLY      16'h8000
`define RES_LSB_ONE        16'h0001
`define RES_ALL_ONES       16'hFFFF

`endif

// ### logic/adc_link_pkg.sv
package adc_link_pkg;
  // device end sequencing
  typedef enum logic [1:0] {DEV_SLEEP, DEV_CONVERT, DEV_READ} dev_state_type;
  // host end sequencing
  typedef enum logic [3:0] {H_IDLE, H_SETUP, H_START_LO, H_PULSE_HI, H_PULSE_LO,
                            H_WAIT, H_READ_LO, H_READ_HI, H_PUSH} host_state_type;
endpackage

// ### logic/adc_link_if.sv
`timescale 1ns/10ps
interface adc_link_if;
  logic sclk;                 // serial clock, host drives, idles high
  logic channel_select_low;   // channel select, low bit
  logic channel_select_high;  // channel select, high bit
  logic result_data_out;      // data / status line, device drives

  modport device (
    input  sclk,
    input  channel_select_low,
    input  channel_select_high,
    output result_data_out
  );
  modport host (
    output sclk,
    output channel_select_low,
    output channel_select_high,
    input  result_data_out
  );
endinterface

// ### logic/adc_device.sv
// Operation
// - idle sleep, clock and data lines high
// - start falling edge wakes, starts conversion
// - channel select latched at start edge
// - latched channel steers mux whole conversion
// - window edge drops bit, halves time
// - floor ten bits, edges past six ignored
// - accepted reduction edge drives data high
// - acknowledge drops on clock high/window end
// - completion drives data high, sleeps after last bit read
// - each later falling edge shows next bit
// - two's complement, sign first, MSB down
// - full result: sign plus fifteen bits
// - host gives seventeen falling edges per cycle
// - host reduces only inside the window
// - code 00..11 selects inputs one..four
// - sign-only pattern never emitted
`timescale 1ns/10ps
`include "adc_link_params.svh"

module adc_device
  import adc_link_pkg::*;
#(
  parameter int CONV_CYC = `CONV_TIME_NS / `CLK_PERIOD_NS,   // full-resolution conversion
  parameter int WIN_CYC  = `WINDOW_TIME_NS / `CLK_PERIOD_NS  // reduction window length
) (
  // clock, reset, enable
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        CE,
  // serial link
  adc_link_if.device       LINK,
  // front end side
  input  wire logic [15:0] SAMPLE_IN,
  output      logic [1:0]  CHAN_SEL,
  output      logic        BUSY
);

  // ----------------------------------------------------------------
  // widths and state
  // ----------------------------------------------------------------
  localparam int CONV_W = $clog2(CONV_CYC + 1);  // conversion timer width
  localparam int WIN_W  = $clog2(WIN_CYC + 1);   // window timer width

  typedef struct packed {
    logic                       sclk_s1;   // sync stage one
    logic                       sclk_s2;   // sync stage two
    logic                       sclk_d;    // delayed copy, edge finder
    logic [1:0]                 sel_s1;    // select sync stage one
    logic [1:0]                 sel_s2;    // select sync stage two
    dev_state_type              st;        // sleep / convert / read
    logic [1:0]                 chan;      // latched channel code
    logic [2:0]                 red;       // reductions taken
    logic [WIN_W-1:0]           win;       // window cycles left
    logic [CONV_W-1:0]          conv;      // conversion cycles left
    logic [`RES_BIT_CNT_W-1:0]  bits;      // result bits still to send
    logic [15:0]                sh;        // result, left aligned
    logic                       dout;      // data line level
    logic                       busy;      // converting
  } dev_reg_type;

  localparam dev_reg_type RESET_VAL = '{
    sclk_s1: 1'b1, sclk_s2: 1'b1, sclk_d: 1'b1,
    sel_s1: 2'h0, sel_s2: 2'h0, st: DEV_SLEEP, chan: 2'h0,
    red: 3'h0, win: '0, conv: '0, bits: '0, sh: 16'h0000,
    dout: 1'b1, busy: 1'b0};

  dev_reg_type r;     // registered state
  dev_reg_type n;     // next state

  logic              sclk_fall;   // falling edge seen on synced clock
  logic              sclk_rise;   // rising edge seen on synced clock
  logic              in_window;   // reduction window still open
  logic [15:0]       result_cut;  // sample cut to current resolution

  // ----------------------------------------------------------------
  // result shaping
  // ----------------------------------------------------------------
  // keep the top N bits; if only the sign would remain, set the lowest
  // kept bit so the reserved pattern can never leave the device
  function automatic logic [15:0] shape_result(input logic [15:0] v,
                                               input logic [2:0]  red);
    logic [15:0] mask;
    logic [15:0] t;
    mask = `RES_ALL_ONES << red;
    t    = v & mask;
    if (t == `RES_SIGN_ONLY) begin
      t = t | (`RES_LSB_ONE << red);
    end
    return t;
  endfunction

  // ----------------------------------------------------------------
  // edge finding
  // ----------------------------------------------------------------
  // only the second stage and its delayed copy are compared, so a
  // metastable first stage never reaches logic
  always_comb begin
    sclk_fall  = r.sclk_d & ~r.sclk_s2;
    sclk_rise  = ~r.sclk_d & r.sclk_s2;
    in_window  = (r.win != '0);
    result_cut = shape_result(SAMPLE_IN, r.red);
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    n = r;
    // pin synchronisers
    n.sclk_s1 = LINK.sclk;
    n.sclk_s2 = r.sclk_s1;
    n.sclk_d  = r.sclk_s2;
    n.sel_s1  = {LINK.channel_select_high, LINK.channel_select_low};
    n.sel_s2  = r.sel_s1;

    case (r.st)
      // asleep, line held high until a start edge
      DEV_SLEEP: begin
        n.dout = 1'b1;
        n.busy = 1'b0;
        if (sclk_fall) begin
          // wake, latch the channel, arm both timers
          n.st   = DEV_CONVERT;
          n.chan = r.sel_s2;
          n.red  = 3'h0;
          n.win  = WIN_W'(WIN_CYC);
          n.conv = CONV_W'(CONV_CYC);
          n.dout = 1'b0;
          n.busy = 1'b1;
        end
      end

      // converting; window open for the first part
      DEV_CONVERT: begin
        if (in_window) begin
          n.win = r.win - 1'b1;
        end
        // acknowledge ends on clock high or window end
        if (r.sclk_s2 || (r.win == WIN_W'(1))) begin
          n.dout = 1'b0;
        end
        if (r.conv <= CONV_W'(1)) begin
          // done: flag it, load the shifter, go quiet
          n.st   = DEV_READ;
          n.sh   = result_cut;
          n.bits = `RES_BIT_CNT_W'(`RES_FULL_BITS) - `RES_BIT_CNT_W'(r.red);
          n.dout = 1'b1;
          n.busy = 1'b0;
          n.win  = '0;
        end else begin
          n.conv = r.conv - 1'b1;
          if (sclk_fall && in_window && (r.red < `RED_MAX)) begin
            // accepted reduction: one bit less, half the time left
            n.red  = r.red + 3'h1;
            n.conv = r.conv >> 1;
            n.dout = 1'b1;
          end
          // edges past the sixth, or after the window, fall through
          // here and change nothing
        end
      end

      // result held, one bit per falling edge
      DEV_READ: begin
        if (sclk_fall) begin
          if (r.bits != '0) begin
            n.dout = r.sh[15];
            n.sh   = {r.sh[14:0], 1'b0};
            n.bits = r.bits - 1'b1;
          end else begin
            // all bits gone: this edge is the next start
            n.st   = DEV_CONVERT;
            n.chan = r.sel_s2;
            n.red  = 3'h0;
            n.win  = WIN_W'(WIN_CYC);
            n.conv = CONV_W'(CONV_CYC);
            n.dout = 1'b0;
            n.busy = 1'b1;
          end
        end else if (sclk_rise && (r.bits == '0)) begin
          // last bit has been taken; drop back to idle high
          n.st   = DEV_SLEEP;
          n.dout = 1'b1;
        end
      end

      default: begin
        n = RESET_VAL;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // low clock enable freezes everything, synchronisers included
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      r <= RESET_VAL;
    end else if (CE) begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from the register
  // ----------------------------------------------------------------
  assign LINK.result_data_out = r.dout;
  assign CHAN_SEL             = r.chan;
  assign BUSY                 = r.busy;

endmodule

// ### logic/adc_host.sv
`timescale 1ns/10ps
`include "adc_link_params.svh"

// ----------------------------------------------------------------
// result buffer
// ----------------------------------------------------------------
module result_fifo #(
  parameter int W = 16,  // word width
  parameter int D = 8    // depth
) (
  input  wire logic         CLK,
  input  wire logic         RST_N,
  input  wire logic         CE,
  input  wire logic         in_valid,
  output      logic         in_ready,
  input  wire logic [W-1:0] in_data,
  output      logic         out_valid,
  input  wire logic         out_ready,
  output      logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;    // storage
    logic [AW-1:0]       wp;     // write pointer
    logic [AW-1:0]       rp;     // read pointer
    logic [AW:0]         cnt;    // words held
    logic                vld;    // registered not-empty flag
    logic [W-1:0]        head;   // registered copy of the oldest word
  } fifo_reg_type;

  fifo_reg_type r;  // registered state
  fifo_reg_type n;  // next state
  logic         wr; // push this cycle
  logic         rd; // pop this cycle

  // flags come from the count, so full and empty are exact
  always_comb begin
    in_ready  = (r.cnt != (AW+1)'(D));
    out_valid = r.vld;
    out_data  = r.head;
    wr        = in_valid & in_ready;
    rd        = out_valid & out_ready;
    n         = r;
    if (wr) begin
      n.mem[r.wp] = in_data;
      n.wp        = (r.wp == AW'(D - 1)) ? '0 : r.wp + 1'b1;
    end
    if (rd) begin
      n.rp = (r.rp == AW'(D - 1)) ? '0 : r.rp + 1'b1;
    end
    n.cnt = r.cnt + (AW+1)'(wr) - (AW+1)'(rd);
    // outputs leave from flops, so the head is prepared one cycle early
    n.vld  = (n.cnt != '0);
    n.head = n.mem[n.rp];
  end

  // pointer and storage register
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      r <= '0;
    end else if (CE) begin
      r <= n;
    end
  end
endmodule

// ----------------------------------------------------------------
// host end: makes the serial clock, runs one convert-and-read cycle
// ----------------------------------------------------------------
module adc_host
  import adc_link_pkg::*;
#(
  parameter int HALF_CYC = (`SCLK_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,  // half clock period
  parameter int FIFO_D   = 8                                                       // buffered results
) (
  // clock, reset, enable
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        CE,
  // serial link
  adc_link_if.host         LINK,
  // conversion request
  input  wire logic        REQ_VALID,
  output      logic        REQ_READY,
  input  wire logic [1:0]  REQ_CHAN,
  input  wire logic [2:0]  REQ_DROP,
  // result stream
  output      logic        RES_VALID,
  input  wire logic        RES_READY,
  output      logic [15:0] RES_DATA
);
  localparam int HW = $clog2(HALF_CYC + 1);

  typedef struct packed {
    host_state_type            st;      // sequence step
    logic [HW-1:0]             cnt;     // half period timer
    logic                      sclk;    // clock line level
    logic [1:0]                chan;    // channel code driven
    logic [2:0]                drop;    // reductions wanted
    logic [2:0]                npulse;  // reductions sent
    logic [`RES_BIT_CNT_W-1:0] nbits;   // bits still to read
    logic [15:0]               word;    // collected bits
    logic                      d_s1;    // data sync stage one
    logic                      d_s2;    // data sync stage two
    logic                      rdy;     // request ready
  } host_reg_type;

  localparam host_reg_type RESET_VAL = '{
    st: H_IDLE, cnt: '0, sclk: 1'b1, chan: 2'h0, drop: 3'h0, npulse: 3'h0,
    nbits: '0, word: 16'h0000, d_s1: 1'b1, d_s2: 1'b1, rdy: 1'b0};

  host_reg_type r;        // registered state
  host_reg_type n;        // next state
  logic         f_ready;  // buffer has room
  logic         tick;     // half period elapsed

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    n      = r;
    tick   = (r.cnt == '0);
    n.d_s1 = LINK.result_data_out;
    n.d_s2 = r.d_s1;
    if (!tick) begin
      n.cnt = r.cnt - 1'b1;
    end
    case (r.st)
      // wait for a request; refuse while the buffer is full
      H_IDLE: begin
        n.sclk = 1'b1;
        n.rdy  = f_ready;
        if (REQ_VALID && r.rdy) begin
          n.rdy  = 1'b0;
          n.chan = REQ_CHAN;
          n.drop = (REQ_DROP > `RED_MAX) ? `RED_MAX : REQ_DROP;
          n.cnt  = HW'(HALF_CYC);
          n.st   = H_SETUP;
        end
      end
      // select lines settle before the start edge
      H_SETUP: if (tick) begin
        n.sclk   = 1'b0;
        n.npulse = 3'h0;
        n.cnt    = HW'(HALF_CYC);
        n.st     = H_START_LO;
      end
      H_START_LO: if (tick) begin
        n.sclk = 1'b1;
        n.cnt  = HW'(HALF_CYC);
        n.st   = H_PULSE_HI;
      end
      // reduction edges go out back to back, well inside the window
      H_PULSE_HI: if (tick) begin
        n.cnt = HW'(HALF_CYC);
        if (r.npulse < r.drop) begin
          n.sclk   = 1'b0;
          n.npulse = r.npulse + 3'h1;
          n.st     = H_PULSE_LO;
        end else begin
          n.nbits = `RES_BIT_CNT_W'(`RES_FULL_BITS) - `RES_BIT_CNT_W'(r.drop);
          n.st    = H_WAIT;
        end
      end
      H_PULSE_LO: if (tick) begin
        n.sclk = 1'b1;
        n.cnt  = HW'(HALF_CYC);
        n.st   = H_PULSE_HI;
      end
      // wait for the completion level before clocking data
      H_WAIT: if (tick && r.d_s2) begin
        n.sclk = 1'b0;
        n.cnt  = HW'(HALF_CYC);
        n.st   = H_READ_LO;
      end
      // sample late in the low half, after both sync delays
      H_READ_LO: if (tick) begin
        n.word  = {r.word[14:0], r.d_s2};
        n.nbits = r.nbits - 1'b1;
        n.sclk  = 1'b1;
        n.cnt   = HW'(HALF_CYC);
        n.st    = H_READ_HI;
      end
      H_READ_HI: if (tick) begin
        if (r.nbits == '0) begin
          n.word = r.word << r.drop;  // left align short results
          n.st   = H_PUSH;
        end else begin
          n.sclk = 1'b0;
          n.cnt  = HW'(HALF_CYC);
          n.st   = H_READ_LO;
        end
      end
      // stalls here while the buffer is full
      H_PUSH: if (f_ready) begin
        n.st = H_IDLE;
      end
      default: begin
        n = RESET_VAL;
      end
    endcase
  end

  // state register, frozen while CE is low
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      r <= RESET_VAL;
    end else if (CE) begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // buffer and outputs
  // ----------------------------------------------------------------
  result_fifo #(.W(16), .D(FIFO_D)) u_fifo (
    .CLK       (CLK),
    .RST_N     (RST_N),
    .CE        (CE),
    .in_valid  (r.st == H_PUSH),
    .in_ready  (f_ready),
    .in_data   (r.word),
    .out_valid (RES_VALID),
    .out_ready (RES_READY),
    .out_data  (RES_DATA)
  );

  assign LINK.sclk                = r.sclk;
  assign LINK.channel_select_low  = r.chan[0];
  assign LINK.channel_select_high = r.chan[1];
  assign REQ_READY                = r.rdy;
endmodule

// ### test/adc_link_checker.sv
`timescale 1ns/10ps
module adc_link_checker #(
  parameter int WIN_CYC = 200  // reduction window length in cycles
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // link lines
  input wire logic sclk,
  input wire logic channel_select_low,
  input wire logic channel_select_high,
  input wire logic result_data_out
);
  // ----------------------------------------------------------------
  // link monitor state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       sclk_q;   // clock line one sample ago
    logic       data_q;   // data line one sample ago
    logic       in_conv;  // start seen, completion not yet
    logic [4:0] fidx;     // fall index within one 17-edge cycle
    logic [2:0] red;      // reductions seen this conversion
    logic [9:0] fage;     // samples since last fall
    logic [9:0] rage;     // samples since last rise
    logic [9:0] wage;     // samples since start fall
  } mon_type;
  localparam mon_type MON_RST = '{sclk_q: 1'b1, data_q: 1'b1, default: '0};
  mon_type mon_r;      // registered monitor state
  mon_type mon_nxt;    // next monitor state
  logic    fall;       // clock line fall seen
  logic    rise;       // clock line rise seen
  logic    done_rise;  // completion: rise far from any fall
  assign fall = mon_r.sclk_q & ~sclk;
  assign rise = ~mon_r.sclk_q & sclk;
  // an ack rises 3 samples after a fall, so a later rise means completion
  assign done_rise = mon_r.in_conv & result_data_out & ~mon_r.data_q & (mon_r.fage > 10'h008);

  // saturating age counter
  function automatic logic [9:0] inc(input logic [9:0] v);
    return (v == 10'h3FF) ? v : v + 10'h001;
  endfunction

  // next state: track edges and the phase of the cycle
  always_comb begin
    mon_nxt = mon_r;
    mon_nxt.sclk_q = sclk;
    mon_nxt.data_q = result_data_out;
    mon_nxt.fage = inc(mon_r.fage);
    mon_nxt.rage = inc(mon_r.rage);
    mon_nxt.wage = inc(mon_r.wage);
    if (rise) begin
      mon_nxt.rage = 10'h001;
    end
    if (fall) begin
      mon_nxt.fage = 10'h001;
      mon_nxt.fidx = (mon_r.fidx == 5'h10) ? 5'h00 : mon_r.fidx + 5'h01;
      if (mon_r.fidx == 5'h00) begin  // start edge
        mon_nxt.in_conv = 1'b1;
        mon_nxt.red = 3'h0;
        mon_nxt.wage = 10'h001;
      end else if (mon_r.in_conv) begin  // reduction edge
        mon_nxt.red = mon_r.red + 3'h1;
      end
    end
    if (done_rise) begin
      mon_nxt.in_conv = 1'b0;
    end
  end

  // state register
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      mon_r <= MON_RST;
    end else begin
      mon_r <= mon_nxt;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_idle_after_reset;
    $rose(RST_N) |-> sclk && result_data_out;
  endproperty
  a_idle_after_reset: assert property (p_idle_after_reset) else $error("link not idle after reset");
  property p_sleep_at_start;
    fall && mon_r.fidx == 5'h00 |-> result_data_out;
  endproperty
  a_sleep_at_start: assert property (p_sleep_at_start) else $error("start while not asleep");
  property p_start_low;
    fall && mon_r.fidx == 5'h00 |-> ##6 (!result_data_out)[*8];
  endproperty
  a_start_low: assert property (p_start_low) else $error("data not low after start");
  property p_sel_stable;
    fall && mon_r.fidx == 5'h00 |-> ($stable({channel_select_high, channel_select_low}))[*4];
  endproperty
  a_sel_stable: assert property (p_sel_stable) else $error("select moved at start");
  property p_ack;
    fall && mon_r.in_conv |-> ##[2:6] result_data_out;
  endproperty
  a_ack: assert property (p_ack) else $error("reduction not acknowledged");
  property p_ack_drop;
    rise && mon_r.in_conv |-> ##[2:6] !result_data_out;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("ack did not drop");
  property p_done_hold;
    done_rise |-> result_data_out[*5];
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("completion level not held");
  property p_read_timing;
    !mon_r.in_conv && $changed(result_data_out) |->
      (mon_r.fage >= 10'h002 && mon_r.fage <= 10'h006) || (mon_r.rage >= 10'h002 && mon_r.rage <= 10'h006);
  endproperty
  a_read_timing: assert property (p_read_timing) else $error("data moved without clock edge");
  property p_red_window;
    fall && mon_r.in_conv |-> mon_r.wage < WIN_CYC && mon_r.red < 3'h6;
  endproperty
  a_red_window: assert property (p_red_window) else $error("reduction outside window");
endmodule

// ### test/serial_adc_conversion_port_tb.sv
`timescale 1ns/10ps
module serial_adc_conversion_port_tb;
  // ----------------------------------------------------------------
  // setup
  // ----------------------------------------------------------------
  localparam int CONV_CYC = 4000;   // shortened conversion keeps run brief
  localparam int WIN_CYC  = 200;    // shortened window, still holds 6 pulses
  localparam int LIMIT    = 60000;  // watchdog ceiling in cycles
  // row: channel, reductions, sample, expected word
  localparam logic [36:0] ROWS [8] = '{
    {2'h0, 3'h0, 16'h1234, 16'h1234},
    {2'h1, 3'h1, 16'h7FFF, 16'h7FFE},
    {2'h2, 3'h2, 16'hFFFF, 16'hFFFC},
    {2'h3, 3'h3, 16'hA5A5, 16'hA5A0},
    {2'h0, 3'h4, 16'h0001, 16'h0000},
    {2'h1, 3'h5, 16'h8000, 16'h8020},
    {2'h2, 3'h6, 16'h803F, 16'h8040},
    {2'h3, 3'h7, 16'hC3C3, 16'hC3C0}
  };
  logic        clk, rst_n, ce;           // clock, reset, enable
  logic        req_valid, req_ready;     // request handshake
  logic [1:0]  req_chan, chan_sel;       // channel asked, channel latched
  logic [2:0]  req_drop;                 // reductions asked
  logic        res_valid, res_ready;     // result handshake
  logic [15:0] res_data, sample;         // result word, front-end sample
  logic        busy;                     // converting
  int          err_count, n_compared, cyc, got;

  adc_link_if u_adc_link_if();
  adc_device #(.CONV_CYC(CONV_CYC), .WIN_CYC(WIN_CYC)) u_adc_device (
    .CLK(clk), .RST_N(rst_n), .CE(ce), .LINK(u_adc_link_if.device),
    .SAMPLE_IN(sample), .CHAN_SEL(chan_sel), .BUSY(busy));
  adc_host u_adc_host (
    .CLK(clk), .RST_N(rst_n), .CE(ce), .LINK(u_adc_link_if.host),
    .REQ_VALID(req_valid), .REQ_READY(req_ready), .REQ_CHAN(req_chan), .REQ_DROP(req_drop),
    .RES_VALID(res_valid), .RES_READY(res_ready), .RES_DATA(res_data));
  adc_link_checker #(.WIN_CYC(WIN_CYC)) u_adc_link_checker (
    .CLK(clk), .RST_N(rst_n), .sclk(u_adc_link_if.sclk),
    .channel_select_low(u_adc_link_if.channel_select_low),
    .channel_select_high(u_adc_link_if.channel_select_high),
    .result_data_out(u_adc_link_if.result_data_out));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results;
    if (err_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // levels that both ends must show while held in reset
  task automatic idle_check;
    check("sclk", 16'(u_adc_link_if.sclk), 16'h0001);
    check("data", 16'(u_adc_link_if.result_data_out), 16'h0001);
    check("busy", 16'(busy), 16'h0000);
    check("chan_sel", 16'(chan_sel), 16'h0000);
  endtask

  // waits for an idle host so the previous sample is no longer read
  task automatic send(input logic [36:0] row);
    while (req_ready !== 1'b1) @(posedge clk);
    sample <= row[31:16];
    req_chan <= row[36:35];
    req_drop <= row[34:32];
    req_valid <= 1'b1;
    do @(posedge clk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    while (busy !== 1'b1) @(posedge clk);
    check("chan_sel", 16'(chan_sel), 16'(row[36:35]));
  endtask

  // ----------------------------------------------------------------
  // clock and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_count = err_count + 1;
      results();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    req_valid = 1'b0;
    req_chan = 2'h0;
    req_drop = 3'h0;
    res_ready = 1'b0;
    sample = 16'h0000;
    err_count = 0;
    n_compared = 0;
    repeat (2) @(posedge clk);
    idle_check();
    rst_n <= 1'b1;
    // fill the buffer with every resolution while the sink stalls
    for (int i = 0; i < 8; i++) begin
      send(ROWS[i]);
    end
    while (busy === 1'b1) @(posedge clk);
    // buffer full: a further request must wait
    sample <= ROWS[0][31:16];
    req_chan <= ROWS[0][36:35];
    req_drop <= ROWS[0][34:32];
    req_valid <= 1'b1;
    repeat (6000) @(posedge clk);
    check("req_ready", 16'(req_ready), 16'h0000);
    check("res_valid", 16'(res_valid), 16'h0001);
    // drain; the held request then goes through as a ninth word
    res_ready <= 1'b1;
    got = 0;
    while (got < 9) begin
      @(posedge clk);
      if (req_valid === 1'b1 && req_ready === 1'b1) req_valid <= 1'b0;
      if (res_valid === 1'b1) begin
        check("res_data", res_data, ROWS[got % 8][15:0]);
        got = got + 1;
      end
    end
    // reset in mid-conversion, then a clean cycle must still work
    send(ROWS[3]);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    idle_check();
    rst_n <= 1'b1;
    send(ROWS[6]);
    while (res_valid !== 1'b1) @(posedge clk);
    check("res_data", res_data, ROWS[6][15:0]);
    results();
  end
endmodule
